/* File: core/ffr_pkg.sv */
/*
 * Constants, carrier structs and state encodings for the fault flash code
 * reporter. Assumes a single 125 MHz core clock and APB register access.
 */
package ffr_pkg;
    // *****************************************************************
    // timing
    // *****************************************************************
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned FLASH_HALF_MS = 250;
    localparam int unsigned PAUSE_MS = 1500;
    localparam int unsigned FLASH_HALF_CYC_DEF = CLK_HZ / 1000 * FLASH_HALF_MS;
    localparam int unsigned PAUSE_CYC_DEF = CLK_HZ / 1000 * PAUSE_MS;
    localparam int unsigned TICK_W = 32;

    // *****************************************************************
    // flash counts
    // *****************************************************************
    localparam logic [2:0] CNT_NONE = 3'h0;
    localparam logic [2:0] CNT_SWITCH = 3'h2;
    localparam logic [2:0] CNT_JUMPER = 3'h3;
    localparam logic [2:0] CNT_RETRIG = 3'h4;
    localparam logic [2:0] CNT_CROSS = 3'h4;
    localparam logic [2:0] CNT_LINK = 3'h5;
    localparam logic [2:0] CNT_OUTPAIR = 3'h6;

    // *****************************************************************
    // register map (byte addresses)
    // *****************************************************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_SWITCH = 12'h008;
    localparam logic [11:0] ADDR_STORED = 12'h00C;
    localparam int unsigned SW_W = 8;
    // ctrl bit positions
    localparam int unsigned CTRL_CFG_VALID = 0;
    localparam int unsigned CTRL_NONRETRIG = 1;
    localparam int unsigned CTRL_DUAL_IN = 2;
    localparam int unsigned CTRL_SS_OUT = 3;
    localparam int unsigned CTRL_DELAY_VAR = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

    typedef enum {ST_OFF, ST_ON, ST_PAUSE} ffr_phase_e;

    // sense inputs from the pin-level test circuitry
    typedef struct packed {
        logic link_short_supply;
        logic link_short_pulse1;
        logic link_short_common;
        logic link_driven;
        logic pulse2_short_supply;
        logic outpair_test_fail;
        logic pulse_cross_short;
        logic jumper_present;
        logic exp_out_energize;
        logic logic_in;
        logic timer_running;
        logic timer_expired;
    } ffr_sense_s;

    typedef struct packed {
        logic red;
        logic green;
    } ffr_led_s;
endpackage

/* File: core/ffr_reporter.sv */
/*
 * Fault detection latches and flash code sequencer driving the power and
 * fault indicator, with an APB slave for configuration and status.
 * Assumes sense inputs synchronous to CORE_CLK and NRST only at power-up.
 */
`timescale 1ns/10ps
module ffr_reporter
    import ffr_pkg::*;
#(
    parameter int unsigned FLASH_HALF_CYC = FLASH_HALF_CYC_DEF,
    parameter int unsigned PAUSE_CYC = PAUSE_CYC_DEF
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire ffr_sense_s SENSE,
    input wire logic [SW_W-1:0] SWITCH_POS,
    output ffr_led_s LED,
    output logic FAULT_MODE
);
    // *****************************************************************
    // state
    // *****************************************************************
    typedef struct packed {
        logic [31:0] ctrl;
        logic [SW_W-1:0] stored;
        logic link_flt;
        logic outpair_flt;
        logic cross_flt;
        logic switch_flt;
        logic jumper_flt;
        logic jumper_seen;
        logic retrig_flt;
        logic in_prev;
        logic in_dropped;
        logic exp_prev;
        ffr_phase_e phase;
        logic [TICK_W-1:0] tick;
        logic [2:0] flash_n;
        logic [2:0] code;
        logic code_bg;
        logic [31:0] rdata;
        ffr_led_s led;
    } ffr_state_s;

    ffr_state_s st;
    ffr_state_s next_st;

    // terminal tick value for a phase lasting n cycles
    function automatic logic [TICK_W-1:0] ffr_cyc(input int unsigned n);
        return TICK_W'(n - 1);
    endfunction

    // current code, highest-priority latched fault first
    function automatic logic [3:0] ffr_pick(input ffr_state_s s);
        if (s.outpair_flt) begin
            return {1'b0, CNT_OUTPAIR};
        end else if (s.link_flt) begin
            return {1'b0, CNT_LINK};
        end else if (s.cross_flt) begin
            return {1'b0, CNT_CROSS};
        end else if (s.retrig_flt) begin
            return {1'b1, CNT_RETRIG};
        end else if (s.jumper_flt) begin
            return {1'b1, CNT_JUMPER};
        end else if (s.switch_flt) begin
            return {1'b1, CNT_SWITCH};
        end
        return {1'b1, CNT_NONE};
    endfunction

    logic apb_wr;
    logic apb_rd;
    logic [3:0] sel;
    logic rise_in;
    logic fall_in;
    logic exp_rise;
    logic solid;

    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_rd = PSEL && !PENABLE && !PWRITE;
    assign rise_in = SENSE.logic_in && !st.in_prev;
    assign fall_in = !SENSE.logic_in && st.in_prev;
    assign exp_rise = SENSE.exp_out_energize && !st.exp_prev;
    assign solid = st.link_flt || st.outpair_flt || st.cross_flt;

    // *****************************************************************
    // next-state logic
    // *****************************************************************
    always_comb begin
        next_st = st;
        sel = ffr_pick(st);
        next_st.in_prev = SENSE.logic_in;
        next_st.exp_prev = SENSE.exp_out_energize;

        // register writes; zero-wait slave
        if (apb_wr && PADDR == ADDR_CTRL) begin
            next_st.ctrl = PWDATA;
        end
        if (apb_wr && PADDR == ADDR_STORED) begin
            next_st.stored = PWDATA[SW_W-1:0];
        end

        // solid faults only ever set; reset is the power cycle
        if (SENSE.link_short_supply || SENSE.link_short_pulse1) begin
            next_st.link_flt = 1'b1;
        end
        if (SENSE.link_short_common && SENSE.link_driven) begin
            next_st.link_flt = 1'b1;
        end
        if (st.ctrl[CTRL_DUAL_IN] && st.ctrl[CTRL_CFG_VALID] && SENSE.pulse2_short_supply) begin
            next_st.link_flt = 1'b1;
        end
        if (st.ctrl[CTRL_SS_OUT] && SENSE.outpair_test_fail) begin
            next_st.outpair_flt = 1'b1;
        end
        if (SENSE.pulse_cross_short) begin
            next_st.cross_flt = 1'b1;
        end

        // switch mismatch follows the switches live
        next_st.switch_flt = st.ctrl[CTRL_CFG_VALID] && (SWITCH_POS != st.stored);

        // jumper shown at next energize, gone when removed; one fitted while
        // still unconfigured is remembered and accepted, only a late one faults
        if (!SENSE.jumper_present) begin
            next_st.jumper_flt = 1'b0;
            next_st.jumper_seen = 1'b0;
        end else begin
            if (!st.ctrl[CTRL_CFG_VALID]) begin
                next_st.jumper_seen = 1'b1;
            end
            if (exp_rise && st.ctrl[CTRL_CFG_VALID] && !st.jumper_seen) begin
                next_st.jumper_flt = 1'b1;
            end
        end

        // retrigger watch on the delay variant
        if (st.ctrl[CTRL_DELAY_VAR] && st.ctrl[CTRL_NONRETRIG]) begin
            if (fall_in && SENSE.timer_running) begin
                next_st.in_dropped = 1'b1;
            end
            if (SENSE.timer_expired) begin
                next_st.in_dropped = 1'b0;
                next_st.retrig_flt = 1'b0;
            end else if (st.retrig_flt && rise_in) begin
                next_st.retrig_flt = 1'b0;
                next_st.in_dropped = 1'b0;
            end else if (st.in_dropped && rise_in) begin
                next_st.retrig_flt = 1'b1;
                next_st.in_dropped = 1'b0;
            end
        end else begin
            next_st.retrig_flt = 1'b0;
            next_st.in_dropped = 1'b0;
        end

        // flash sequencer: count flashes, then a pause, then repeat
        next_st.tick = st.tick + TICK_W'(1);
        case (st.phase)
            ST_PAUSE: begin
                if (st.tick >= ffr_cyc(PAUSE_CYC)) begin
                    next_st.tick = '0;
                    next_st.code = sel[2:0];
                    next_st.code_bg = sel[3];
                    next_st.flash_n = '0;
                    next_st.phase = (sel[2:0] == CNT_NONE) ? ST_PAUSE : ST_ON;
                end
            end
            ST_ON: begin
                if (st.tick >= ffr_cyc(FLASH_HALF_CYC)) begin
                    next_st.tick = '0;
                    next_st.flash_n = st.flash_n + 3'h1;
                    next_st.phase = ST_OFF;
                end
            end
            ST_OFF: begin
                if (st.tick >= ffr_cyc(FLASH_HALF_CYC)) begin
                    next_st.tick = '0;
                    next_st.phase = (st.flash_n >= st.code) ? ST_PAUSE : ST_ON;
                end
            end
            default: begin
                next_st.phase = ST_PAUSE;
                next_st.tick = '0;
            end
        endcase

        // indicator: red flashes over green, or alone when latched or unconfigured
        next_st.led.red = (next_st.phase == ST_ON);
        if (!st.ctrl[CTRL_CFG_VALID]) begin
            next_st.led.green = 1'b0;
        end else if (solid) begin
            next_st.led.green = 1'b0;
        end else begin
            next_st.led.green = !(next_st.phase == ST_ON);
        end

        // read data registered in the setup cycle
        if (apb_rd) begin
            case (PADDR)
                ADDR_CTRL: next_st.rdata = st.ctrl;
                ADDR_STATUS: next_st.rdata = {22'h0, st.code_bg, st.code, st.retrig_flt,
                    st.jumper_flt, st.switch_flt, st.cross_flt, st.outpair_flt, st.link_flt};
                ADDR_SWITCH: next_st.rdata = {{(32 - SW_W){1'b0}}, SWITCH_POS};
                ADDR_STORED: next_st.rdata = {{(32 - SW_W){1'b0}}, st.stored};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // *****************************************************************
    // state register
    // *****************************************************************
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
            st.phase <= ST_PAUSE;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign PRDATA = st.rdata;
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign LED = st.led;
    assign FAULT_MODE = solid;
endmodule // ffr_reporter

/* File: dv/ffr_field.sv */
/* field wiring and input devices model
   bench asks for each condition by bit */
`timescale 1ns/10ps
module ffr_field
    import ffr_pkg::*;
(
    input wire logic clk,
    input wire logic [11:0] want,
    output ffr_sense_s sense
);
    // conditions show one edge after asked, no glitches
    always_ff @(posedge clk) begin
        sense <= ffr_sense_s'(want);
    end
endmodule // ffr_field

/* File: dv/ffr_monitor.sv */
/* checker for the flash code reporter
   sees top ports only; bound from tb_top */
`timescale 1ns/10ps
module ffr_monitor
    import ffr_pkg::*;
#(parameter int unsigned FLASH_HALF_CYC = FLASH_HALF_CYC_DEF) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire ffr_sense_s SENSE,
    input wire ffr_led_s LED,
    input wire logic FAULT_MODE
);
    int unsigned run;
    logic ss_var;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    // length of the red flash so far
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) run <= 0;
        else run <= LED.red ? run + 1 : 0;
    end
    // shadow of the solid-state variant bit; pair test only counts on that variant
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) ss_var <= CTRL_RESET[CTRL_SS_OUT];
        else if (PSEL && PENABLE && PWRITE && PADDR == ADDR_CTRL) ss_var <= PWDATA[CTRL_SS_OUT];
    end
    chk_link_short: assert property ((SENSE.link_short_supply || SENSE.link_short_pulse1) |-> ##[1:2] FAULT_MODE)
        else $error("link short not flagged");
    chk_link_common: assert property ((SENSE.link_short_common && SENSE.link_driven) |-> ##[1:2] FAULT_MODE)
        else $error("link common short not flagged");
    chk_outpair_fail: assert property ((ss_var && SENSE.outpair_test_fail) |-> ##[1:2] FAULT_MODE)
        else $error("output pair fault not flagged");
    chk_cross_fault: assert property (SENSE.pulse_cross_short |-> ##[1:2] FAULT_MODE)
        else $error("cross fault not flagged");
    chk_fault_latch: assert property (FAULT_MODE |=> FAULT_MODE)
        else $error("solid fault cleared without reset");
    chk_green_dark: assert property (FAULT_MODE && $past(FAULT_MODE) |-> !LED.green)
        else $error("green shown under solid fault");
    chk_led_exclusive: assert property (!(LED.red && LED.green))
        else $error("red and green together");
    chk_flash_width: assert property ($fell(LED.red) |-> run == FLASH_HALF_CYC)
        else $error("red flash of wrong length");
endmodule // ffr_monitor

/* File: dv/tb_top.sv */
/* table and hand tests for the flash code reporter
   shortened flash timing: half 4, pause 10 */
`timescale 1ns/10ps
module tb_top;
    import ffr_pkg::*;
    typedef struct packed {logic [11:0] s; logic [5:0] st; logic [2:0] code;} ffr_row_s;
    logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, pready, pslverr, fm;
    logic [11:0] paddr = 0, want = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [1:0] lg;
    logic [7:0] sw = 0;
    ffr_sense_s sense;
    ffr_led_s led;
    int n_errors = 0, compares = 0, n;
    ffr_row_s rows [8] = '{'{12'h000, 6'h00, 3'h0}, '{12'h800, 6'h01, 3'h5}, '{12'h400, 6'h01, 3'h5},
        '{12'h300, 6'h01, 3'h5}, '{12'h200, 6'h00, 3'h0}, '{12'h080, 6'h01, 3'h5},
        '{12'h040, 6'h02, 3'h6}, '{12'h020, 6'h04, 3'h4}};
    always #4 clk = ~clk;
    ffr_reporter #(.FLASH_HALF_CYC(4), .PAUSE_CYC(10)) ffr_reporter_i (.CORE_CLK(clk), .NRST(nrst),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SENSE(sense), .SWITCH_POS(sw), .LED(led), .FAULT_MODE(fm));
    ffr_field ffr_field_i (.clk(clk), .want(want), .sense(sense));
    task results();
        if (n_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // one apb transfer, held until pready seen
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
        int i;
        psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) chk(0, 1, "no pready");
        rd = prdata;
        chk(pslverr, 0, "slave error");
        psel <= 0; pen <= 0;
        @(posedge clk);
    endtask
    task step(input logic [11:0] v);
        want <= v;
        repeat (3) @(posedge clk);
    endtask
    task st_bit(input int b, input logic e, input string m);
        apb(0, ADDR_STATUS, 0, r);
        chk(r[b], e, m);
    endtask
    // skip to a pause, then count red flashes up to the next pause
    task flashes(output int c, output logic [1:0] fg);
        int lo;
        logic p;
        bit go;
        c = 0; lo = 0; p = 1; go = 0;
        repeat (300) begin
            @(posedge clk);
            #1;
            fg = {fm, led.green};
            if (go && led.red === 1'b1 && !p) c++;
            lo = (led.red === 1'b1) ? 0 : lo + 1;
            if (lo > 6 && c > 0) break;
            if (lo > 6) go = 1;
            p = led.red;
        end
        @(posedge clk); // back onto the edge so callers drive there
    endtask
    task reset();
        want <= 0;
        nrst <= 0;
        repeat (3) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        chk(0, 1, "timeout");
        results();
    end
    initial begin
        for (int k = 0; k < 8; k++) begin
            reset();
            apb(1, ADDR_STORED, 0, r);
            apb(1, ADDR_CTRL, 32'h0000_001F, r);
            step(rows[k].s);
            step(12'h000); // sense gone, solid faults must hold
            st_bit(0, rows[k].st[0], "link flag");
            chk(r[2:1], rows[k].st[2:1], "pair or cross flag");
            chk(fm, rows[k].st != 0, "fault mode");
            flashes(n, lg);
            chk(n, rows[k].code, "flash count");
            chk(lg[0], rows[k].st == 0, "green");
        end
        reset();
        apb(0, ADDR_CTRL, 0, r);
        chk(r, CTRL_RESET, "ctrl reset");
        apb(1, 12'h010, 32'hFFFF_FFFF, r);
        apb(0, 12'h010, 0, r);
        chk(r, 0, "unmapped read");
        apb(1, ADDR_CTRL, 32'h0000_0013, r);
        apb(1, ADDR_STORED, 32'h0000_005A, r);
        sw <= 8'hA5;
        step(12'h000);
        st_bit(3, 1, "switch flag");
        flashes(n, lg);
        chk(n, 2, "switch flashes");
        chk(lg, 2'b01, "keeps running");
        sw <= 8'h5A;
        step(12'h000);
        st_bit(3, 0, "switch restored");
        step(12'h010); // jumper fitted late
        step(12'h018);
        step(12'h010);
        st_bit(4, 1, "jumper flag");
        flashes(n, lg);
        chk(n, 3, "jumper flashes");
        chk(lg, 2'b01, "jumper over green");
        step(12'h000);
        st_bit(4, 0, "jumper cleared");
        step(12'h006);
        step(12'h002);
        step(12'h006);
        st_bit(5, 1, "retrigger flag");
        flashes(n, lg);
        chk(n, 4, "retrigger flashes");
        chk(lg, 2'b01, "retrigger over green");
        step(12'h002);
        step(12'h006);
        st_bit(5, 0, "cleared by recycle");
        step(12'h002);
        step(12'h006);
        step(12'h007);
        st_bit(5, 0, "cleared by expiry");
        reset();
        step(12'h010); // jumper fitted before configuration
        apb(1, ADDR_CTRL, 32'h0000_0013, r);
        step(12'h018);
        step(12'h010);
        st_bit(4, 0, "early jumper accepted");
        results();
    end
endmodule // tb_top
bind ffr_reporter ffr_monitor #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) ffr_monitor_i (.CORE_CLK(CORE_CLK),
    .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .SENSE(SENSE), .LED(LED), .FAULT_MODE(FAULT_MODE));
